// >>> design/adc_packer_pkg.sv
// Constants, types and timing figures shared by the sample word packer files.
// Assumes one 200 MHz acquisition clock and four simultaneous converters.
//
// Contract
// - Each finished conversion yields one 16-bit word per channel into holding register, and into FIFO for enabled channels.
// - Narrow variant: result in bits 15..2, digital input bits in bits 1..0.
// - Digital input bits are taken when the busy flag rises, after conversion.
// - A conversion starts on the falling edge of the conversion strobe.
// - Narrow bipolar codes are 14-bit two's complement, 2000 to 1FFF.
// - Narrow unipolar codes use the same two's complement, centred at mid-range.
// - Wide bipolar codes are straight binary, 0000 to FFFF, 8000 at zero.
// - Wide unipolar codes are straight binary, 0000 at zero input.
// - Every finished result of an enabled channel is buffered in the data FIFO for the host.
// - No timed scan conversion is acquired before the trigger condition is met; a software command needs no trigger.
// - Conversions start by a single software command or a timed scan.
// - Each channel carries two digital input bits; four bits sampled per word pair.
// - Software sets channel selection, gain and bipolar or unipolar type.
package adc_packer_pkg;
   localparam int NUM_CH = 4;
   localparam int WORD_W = 16;
   localparam int RAW14_W = 14;
   localparam int SDI_W = 2;
   localparam int GAIN_W = 2;
   localparam int INTERVAL_W = 24;
   localparam int RESULT14_LSB = 2;
   localparam int CLK_PERIOD_NS = 5;
   localparam int STROBE_LOW_NS = 50;
   // Least strobe low time, rounded up to whole clock cycles.
   localparam int STROBE_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CNT_W = 4;
   localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
   localparam logic [INTERVAL_W-1:0] COUNT_RESET = 24'h00_0000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAIT_TRIG = 3'b001,
      ST_WAIT_TICK = 3'b010,
      ST_STROBE = 3'b011,
      ST_WAIT_BUSY = 3'b100,
      ST_WAIT_DONE = 3'b101,
      ST_PUSH = 3'b110
   } acq_state_t;
endpackage : adc_packer_pkg

// >>> design/pin_sync.sv
// Two-stage synchroniser for a bundle of pins that arrive from outside the clock domain.
// Assumes the bundle is stable around the edge that the caller looks for.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } sync_state_t;

   sync_state_t s;
   sync_state_t next_s;

   // The first stage feeds only the second stage.
   always_comb begin
      next_s = s;
      next_s.meta = i_d;
      next_s.q = s.meta;
   end

   // Pins idle high after reset so a busy flag does not look like an edge.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s <= '1;
      end else begin
         s <= next_s;
      end
   end

   assign o_q = s.q;
endmodule : pin_sync
`default_nettype wire

// >>> design/sample_code_map.sv
// Maps raw converter codes and digital input bits to 16-bit sample words.
// Assumes converters present offset binary codes, low justified for the narrow variant.
`timescale 1ns/1ps
`default_nettype none
module sample_code_map
   import adc_packer_pkg::*;
#(
   parameter bit WIDE = 1'b0
) (
   input wire logic [NUM_CH*WORD_W-1:0] i_raw,
   input wire logic [NUM_CH*SDI_W-1:0] i_sdi,
   output logic [NUM_CH*WORD_W-1:0] o_word
);
   // Offset binary becomes two's complement by inverting the top bit.
   function automatic logic [WORD_W-1:0] map_word(input logic [WORD_W-1:0] raw,
                                                   input logic [SDI_W-1:0] sdi,
                                                   input bit wide);
      logic [RAW14_W-1:0] twos;
      twos = {~raw[RAW14_W-1], raw[RAW14_W-2:0]};
      if (wide) begin
         map_word = raw;
      end else begin
         map_word = {twos, sdi};
      end
   endfunction : map_word

   // Every channel is mapped the same way; range type lives in the front end.
   always_comb begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
         o_word[ch*WORD_W +: WORD_W] = map_word(i_raw[ch*WORD_W +: WORD_W],
                                                i_sdi[ch*SDI_W +: SDI_W], WIDE);
      end
   end
endmodule : sample_code_map
`default_nettype wire

// >>> design/adc_sample_word_packer.sv
// Acquisition control: starts conversions, captures results and streams sample words.
// Assumes converters and digital inputs on pins, and a FIFO on the same clock.
`timescale 1ns/1ps
`default_nettype none
module adc_sample_word_packer
   import adc_packer_pkg::*;
#(
   parameter bit WIDE = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_scan_mode,
   input wire logic i_sw_convert,
   input wire logic i_arm,
   input wire logic i_trigger,
   input wire logic [INTERVAL_W-1:0] i_scan_interval,
   input wire logic [INTERVAL_W-1:0] i_scan_count,
   input wire logic [NUM_CH-1:0] i_chan_enable,
   input wire logic [NUM_CH*GAIN_W-1:0] i_gain,
   input wire logic [NUM_CH-1:0] i_bipolar,
   input wire logic i_converter_busy_n,
   input wire logic [NUM_CH*WORD_W-1:0] i_adc_raw,
   input wire logic [NUM_CH*SDI_W-1:0] i_sync_digital_in_bits,
   input wire logic i_fifo_ready,
   output logic o_conv_strobe_n,
   output logic [NUM_CH-1:0] o_chan_enable,
   output logic [NUM_CH*GAIN_W-1:0] o_gain,
   output logic [NUM_CH-1:0] o_bipolar,
   output logic [NUM_CH*WORD_W-1:0] o_hold_word,
   output logic [WORD_W-1:0] o_fifo_data,
   output logic o_fifo_valid,
   output logic o_acq_active,
   output logic o_overrun,
   output logic o_done
);
   localparam int SYNC_W = 1 + NUM_CH * WORD_W + NUM_CH * SDI_W;

   typedef struct packed {
      acq_state_t state;
      logic scan;
      logic busy_prev;
      logic [STROBE_CNT_W-1:0] strobe_cnt;
      logic [INTERVAL_W-1:0] interval_cnt;
      logic [INTERVAL_W-1:0] scans_left;
      logic [NUM_CH-1:0] mask;
      logic [1:0] cur_ch;
      logic strobe_n;
      logic [NUM_CH-1:0] chan_enable;
      logic [NUM_CH*GAIN_W-1:0] gain;
      logic [NUM_CH-1:0] bipolar;
      logic [NUM_CH*WORD_W-1:0] hold;
      logic [WORD_W-1:0] fifo_data;
      logic fifo_valid;
      logic overrun;
      logic done;
      logic active;
   } packer_state_t;

   packer_state_t s;
   packer_state_t next_s;

   logic [SYNC_W-1:0] sync_q;
   logic busy_sync;
   logic [NUM_CH*WORD_W-1:0] raw_sync;
   logic [NUM_CH*SDI_W-1:0] sdi_sync;
   logic [NUM_CH*WORD_W-1:0] mapped;
   logic busy_rise;
   logic tick;

   // Busy flag, results and digital inputs share one synchroniser so they stay aligned.
   pin_sync #(
      .W(SYNC_W)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_d({i_converter_busy_n, i_adc_raw, i_sync_digital_in_bits}),
      .o_q(sync_q)
   );

   assign busy_sync = sync_q[SYNC_W-1];
   assign raw_sync = sync_q[NUM_CH*SDI_W +: NUM_CH*WORD_W];
   assign sdi_sync = sync_q[NUM_CH*SDI_W-1:0];

   sample_code_map #(
      .WIDE(WIDE)
   ) u_map (
      .i_raw(raw_sync),
      .i_sdi(sdi_sync),
      .o_word(mapped)
   );

   // Lowest set bit of a channel mask; the order of the words in the FIFO.
   function automatic logic [1:0] lowest_ch(input logic [NUM_CH-1:0] m);
      lowest_ch = 2'h0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (m[i]) begin
            lowest_ch = i[1:0];
         end
      end
   endfunction : lowest_ch

   // Busy rises once the converter has finished; this is the capture moment.
   assign busy_rise = busy_sync && !s.busy_prev;
   // The scan interval counter ticks only while a timed scan is running.
   assign tick = s.scan && (s.state != ST_IDLE) && (s.state != ST_WAIT_TRIG) &&
                 (s.interval_cnt == COUNT_RESET);

   // Next-state logic for the whole acquisition sequence.
   always_comb begin
      next_s = s;
      next_s.busy_prev = busy_sync;
      next_s.done = 1'b0;
      if (tick) begin
         next_s.interval_cnt = (i_scan_interval == COUNT_RESET) ? COUNT_RESET :
                               i_scan_interval - 24'h00_0001;
      end else if (s.interval_cnt != COUNT_RESET) begin
         next_s.interval_cnt = s.interval_cnt - 24'h00_0001;
      end
      // A tick that finds the previous scan still running is lost and flagged.
      if (tick && (s.state != ST_WAIT_TICK)) begin
         next_s.overrun = 1'b1;
      end else if (s.state == ST_IDLE && i_arm) begin
         next_s.overrun = 1'b0;
      end
      case (s.state)
         ST_IDLE: begin
            // Configuration follows software only between acquisitions.
            next_s.chan_enable = i_chan_enable;
            next_s.gain = i_gain;
            next_s.bipolar = i_bipolar;
            if (i_scan_mode && i_arm) begin
               next_s.scan = 1'b1;
               next_s.state = ST_WAIT_TRIG;
            end else if (!i_scan_mode && i_sw_convert) begin
               next_s.scan = 1'b0;
               next_s.strobe_n = 1'b0;
               next_s.strobe_cnt = STROBE_CNT_W'(STROBE_CYC - 1);
               next_s.state = ST_STROBE;
            end
         end
         ST_WAIT_TRIG: begin
            // Nothing is converted until the trigger arrives.
            if (i_trigger) begin
               next_s.scans_left = i_scan_count;
               next_s.interval_cnt = COUNT_RESET;
               if (i_scan_count == COUNT_RESET) begin
                  next_s.done = 1'b1;
                  next_s.state = ST_IDLE;
               end else begin
                  next_s.state = ST_WAIT_TICK;
               end
            end
         end
         ST_WAIT_TICK: begin
            if (tick) begin
               next_s.strobe_n = 1'b0;
               next_s.strobe_cnt = STROBE_CNT_W'(STROBE_CYC - 1);
               next_s.scans_left = s.scans_left - 24'h00_0001;
               next_s.state = ST_STROBE;
            end
         end
         ST_STROBE: begin
            if (s.strobe_cnt == '0) begin
               next_s.strobe_n = 1'b1;
               next_s.state = ST_WAIT_BUSY;
            end else begin
               next_s.strobe_cnt = s.strobe_cnt - 1'b1;
            end
         end
         ST_WAIT_BUSY: begin
            if (!busy_sync) begin
               next_s.state = ST_WAIT_DONE;
            end
         end
         ST_WAIT_DONE: begin
            // Result and digital input bits are latched together at busy release.
            if (busy_rise) begin
               next_s.hold = mapped;
               next_s.mask = s.chan_enable;
               next_s.state = ST_PUSH;
            end
         end
         ST_PUSH: begin
            // One word per enabled channel, lowest first, held until accepted.
            if (!s.fifo_valid || i_fifo_ready) begin
               if (s.mask != '0) begin
                  next_s.cur_ch = lowest_ch(s.mask);
                  next_s.fifo_data = s.hold[lowest_ch(s.mask)*WORD_W +: WORD_W];
                  next_s.fifo_valid = 1'b1;
                  next_s.mask[lowest_ch(s.mask)] = 1'b0;
               end else begin
                  next_s.fifo_valid = 1'b0;
                  if (s.scan && (s.scans_left != COUNT_RESET)) begin
                     next_s.state = ST_WAIT_TICK;
                  end else begin
                     next_s.done = 1'b1;
                     next_s.state = ST_IDLE;
                  end
               end
            end
         end
         default: begin
            next_s.state = ST_IDLE;
         end
      endcase
      next_s.active = (next_s.state != ST_IDLE); // Registered so the status pin cannot glitch.
   end

   // State register; the strobe idles high so no conversion starts at reset.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s <= '0;
         s.state <= ST_IDLE;
         s.busy_prev <= 1'b1;
         s.strobe_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // Outputs come straight from the state register.
   assign o_conv_strobe_n = s.strobe_n;
   assign o_chan_enable = s.chan_enable;
   assign o_gain = s.gain;
   assign o_bipolar = s.bipolar;
   assign o_hold_word = s.hold;
   assign o_fifo_data = s.fifo_data;
   assign o_fifo_valid = s.fifo_valid;
   assign o_acq_active = s.active;
   assign o_overrun = s.overrun;
   assign o_done = s.done;

   // Checks on the sequence, kept beside the logic they guard.
   property p_strobe_start;
      @(posedge i_clk) disable iff (i_rst)
      (s.state == ST_WAIT_TICK && tick) |=> $fell(o_conv_strobe_n);
   endproperty
   a_strobe_start: assert property (p_strobe_start)
      else $error("Scan tick did not start a conversion.");

   property p_strobe_width;
      @(posedge i_clk) disable iff (i_rst)
      $fell(o_conv_strobe_n) |-> !o_conv_strobe_n [*8];
   endproperty
   a_strobe_width: assert property (p_strobe_width)
      else $error("Conversion strobe low too short.");

   property p_sdi_capture;
      @(posedge i_clk) disable iff (i_rst)
      (s.state == ST_WAIT_DONE && busy_rise && !WIDE) |=>
         o_hold_word[SDI_W-1:0] == $past(sdi_sync[SDI_W-1:0]);
   endproperty
   a_sdi_capture: assert property (p_sdi_capture)
      else $error("Digital input bits not captured at busy release.");

   property p_code_narrow;
      @(posedge i_clk) disable iff (i_rst)
      (s.state == ST_WAIT_DONE && busy_rise && !WIDE) |=>
         o_hold_word[WORD_W-1:RESULT14_LSB] ==
         $past({~raw_sync[RAW14_W-1], raw_sync[RAW14_W-2:0]});
   endproperty
   a_code_narrow: assert property (p_code_narrow)
      else $error("Narrow result not in two's complement at bits 15..2.");

   property p_code_wide;
      @(posedge i_clk) disable iff (i_rst)
      (s.state == ST_WAIT_DONE && busy_rise && WIDE) |=>
         o_hold_word[WORD_W-1:0] == $past(raw_sync[WORD_W-1:0]);
   endproperty
   a_code_wide: assert property (p_code_wide)
      else $error("Wide result not straight binary.");

   property p_no_early_start;
      @(posedge i_clk) disable iff (i_rst)
      (s.state == ST_WAIT_TRIG) |=> o_conv_strobe_n;
   endproperty
   a_no_early_start: assert property (p_no_early_start)
      else $error("Conversion started before trigger.");

   property p_fifo_stall;
      @(posedge i_clk) disable iff (i_rst)
      (o_fifo_valid && !i_fifo_ready) |=> o_fifo_valid && $stable(o_fifo_data);
   endproperty
   a_fifo_stall: assert property (p_fifo_stall)
      else $error("FIFO word dropped under back-pressure.");

   property p_word_from_hold;
      @(posedge i_clk) disable iff (i_rst)
      o_fifo_valid |-> o_fifo_data == o_hold_word[s.cur_ch*WORD_W +: WORD_W];
   endproperty
   a_word_from_hold: assert property (p_word_from_hold)
      else $error("FIFO word differs from holding register.");

   property p_ascending;
      @(posedge i_clk) disable iff (i_rst)
      (o_fifo_valid && i_fifo_ready && s.mask != '0) |=> s.cur_ch > $past(s.cur_ch);
   endproperty
   a_ascending: assert property (p_ascending)
      else $error("Channel words out of ascending order.");

   property p_sw_single;
      @(posedge i_clk) disable iff (i_rst)
      (s.state == ST_IDLE && !i_scan_mode && i_sw_convert) |=> !o_conv_strobe_n;
   endproperty
   a_sw_single: assert property (p_sw_single)
      else $error("Software command did not start a conversion.");

   property p_config_latch;
      @(posedge i_clk) disable iff (i_rst)
      (s.state == ST_IDLE) |=> o_gain == $past(i_gain) && o_bipolar == $past(i_bipolar);
   endproperty
   a_config_latch: assert property (p_config_latch)
      else $error("Configuration not taken while idle.");

   property p_c_push;
      @(posedge i_clk) disable iff (i_rst)
      o_fifo_valid && i_fifo_ready;
   endproperty
   c_push: cover property (p_c_push);

   property p_c_stall;
      @(posedge i_clk) disable iff (i_rst)
      o_fifo_valid && !i_fifo_ready;
   endproperty
   c_stall: cover property (p_c_stall);

   property p_c_scan_done;
      @(posedge i_clk) disable iff (i_rst)
      s.scan && o_done;
   endproperty
   c_scan_done: cover property (p_c_scan_done);
endmodule : adc_sample_word_packer
`default_nettype wire

// >>> dv/adc_converter_model.sv
// Behavioural model of the four simultaneous converters and their digital input pins.
// Assumes it watches the packer's strobe and is told by the bench which codes to present.
`timescale 1ns/1ps
`default_nettype none
module adc_converter_model #(
   parameter int BUSY_CYC = 20
) (
   input wire logic i_clk,
   input wire logic i_conv_strobe_n,
   input wire logic [63:0] i_raw_val,
   input wire logic [7:0] i_sdi_val,
   output logic o_converter_busy_n,
   output logic [63:0] o_adc_raw,
   output logic [7:0] o_sync_digital_in_bits
);
   // One conversion per strobe. Before the first the pins show zero; after it, outside the valid window, the inverse.
   // That way a capture taken at conversion start, or late, reads wrong data.
   // One process drives every pin, so the idle values and the conversions never collide.
   initial begin
      o_converter_busy_n = 1'b1;
      o_adc_raw = 64'h0000_0000_0000_0000;
      o_sync_digital_in_bits = 8'h00;
      forever begin
         @(negedge i_conv_strobe_n); // Analog input is taken here.
         @(posedge i_conv_strobe_n);
         repeat (2) @(posedge i_clk);
         o_converter_busy_n <= 1'b0;
         o_adc_raw <= ~i_raw_val;
         o_sync_digital_in_bits <= ~i_sdi_val;
         repeat (BUSY_CYC) @(posedge i_clk);
         // Result and digital bits become valid as busy rises.
         o_converter_busy_n <= 1'b1;
         o_adc_raw <= i_raw_val;
         o_sync_digital_in_bits <= i_sdi_val;
         repeat (5) @(posedge i_clk);
         o_adc_raw <= ~i_raw_val;
         o_sync_digital_in_bits <= ~i_sdi_val;
      end
   end
endmodule : adc_converter_model
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the sample word packer, narrow and wide variants side by side.
// Assumes the converter model file and the design files are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb
   import adc_packer_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic scan_mode = 1'b0, sw_conv = 1'b0, arm = 1'b0, trig = 1'b0, ready = 1'b1;
   logic [23:0] interval = 24'h00_0000, count = 24'h00_0000;
   logic [3:0] chan_en = 4'h0, bipolar = 4'h0;
   logic [7:0] gain = 8'h00, sdi_val = 8'h00, sdi;
   logic [63:0] raw_val = 64'h0000_0000_0000_0000, raw, hold_n, hold_w;
   logic [3:0] o_en;
   logic [7:0] o_gain;
   logic [3:0] o_bip;
   logic busy_n, strobe_n, valid_n, valid_w, done, overrun, acq_active;
   logic [15:0] data_n, data_w;
   logic [15:0] qn[$], qw[$];
   logic [15:0] raw_tab[2][4];
   logic [13:0] code_tab[2][4];
   int num_errors = 0, tests_run = 0, cyc = 0, low_cnt = 0, last_low = 0, nstrobe = 0;

   always #2.5 i_clk = ~i_clk;

   adc_sample_word_packer #(.WIDE(1'b0)) uut (.i_clk(i_clk), .i_rst(i_rst),
      .i_scan_mode(scan_mode), .i_sw_convert(sw_conv), .i_arm(arm), .i_trigger(trig),
      .i_scan_interval(interval), .i_scan_count(count), .i_chan_enable(chan_en),
      .i_gain(gain), .i_bipolar(bipolar), .i_converter_busy_n(busy_n), .i_adc_raw(raw),
      .i_sync_digital_in_bits(sdi), .i_fifo_ready(ready), .o_conv_strobe_n(strobe_n),
      .o_chan_enable(o_en), .o_gain(o_gain), .o_bipolar(o_bip), .o_hold_word(hold_n),
      .o_fifo_data(data_n), .o_fifo_valid(valid_n), .o_acq_active(acq_active),
      .o_overrun(overrun), .o_done(done));
   // The wide variant shares every input, so it runs in lock step with the narrow one.
   adc_sample_word_packer #(.WIDE(1'b1)) uut_wide (.i_clk(i_clk), .i_rst(i_rst),
      .i_scan_mode(scan_mode), .i_sw_convert(sw_conv), .i_arm(arm), .i_trigger(trig),
      .i_scan_interval(interval), .i_scan_count(count), .i_chan_enable(chan_en),
      .i_gain(gain), .i_bipolar(bipolar), .i_converter_busy_n(busy_n), .i_adc_raw(raw),
      .i_sync_digital_in_bits(sdi), .i_fifo_ready(ready), .o_conv_strobe_n(),
      .o_chan_enable(), .o_gain(), .o_bipolar(), .o_hold_word(hold_w),
      .o_fifo_data(data_w), .o_fifo_valid(valid_w), .o_acq_active(), .o_overrun(),
      .o_done());
   adc_converter_model model (.i_clk(i_clk), .i_conv_strobe_n(strobe_n), .i_raw_val(raw_val),
      .i_sdi_val(sdi_val), .o_converter_busy_n(busy_n), .o_adc_raw(raw),
      .o_sync_digital_in_bits(sdi));

   // Record accepted words, strobe lengths and strobe count; also cut a hang short.
   always @(posedge i_clk) begin
      if (valid_n === 1'b1 && ready === 1'b1) qn.push_back(data_n);
      if (valid_w === 1'b1 && ready === 1'b1) qw.push_back(data_w);
      if (strobe_n === 1'b0) begin
         if (low_cnt == 0) nstrobe++;
         low_cnt++;
      end else if (low_cnt != 0) begin
         last_low = low_cnt;
         low_cnt = 0;
      end
      cyc++;
      if (cyc >= 8000) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h timeout", $time, cyc, 8000);
         finish_test();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Waits for the end-of-job pulse; a missing pulse counts as a mismatch.
   task automatic wait_done();
      int k;
      k = 0;
      do begin
         @(posedge i_clk);
         k++;
      end while (done !== 1'b1 && k < 3000);
      chk(k < 3000, 1'b1);
   endtask : wait_done

   // One-cycle request: arm when the flag is set, a software convert otherwise.
   task automatic pulse(input bit to_arm);
      @(posedge i_clk);
      if (to_arm) begin
         arm <= 1'b1;
      end else begin
         sw_conv <= 1'b1;
      end
      @(posedge i_clk);
      arm <= 1'b0;
      sw_conv <= 1'b0;
   endtask : pulse

   // Single software conversions over the code tables, all channels enabled.
   task automatic t_codes();
      for (int c = 0; c < 2; c++) begin
         qn.delete();
         qw.delete();
         sdi_val <= 8'b10_01_11_00 ^ {c[3:0], c[3:0]};
         raw_val <= {raw_tab[c][3], raw_tab[c][2], raw_tab[c][1], raw_tab[c][0]};
         pulse(1'b0);
         wait_done();
         chk(last_low, STROBE_CYC);
         chk(qn.size(), 4);
         chk(qw.size(), 4);
         for (int ch = 0; ch < 4 && qn.size() == 4 && qw.size() == 4; ch++) begin
            chk(qn[ch][15:2], code_tab[c][ch]);
            chk(qn[ch][1:0], sdi_val[2*ch +: 2]);
            chk(qw[ch], raw_tab[c][ch]);
            chk(hold_n[16*ch +: 16], qn[ch]);
            chk(hold_w[16*ch +: 16], qw[ch]);
         end
      end
      $display("test codes done");
   endtask : t_codes

   // Two channels enabled while the FIFO stalls; the word must wait unchanged.
   task automatic t_stall();
      logic [15:0] first;
      qn.delete();
      chan_en <= 4'b1010;
      ready <= 1'b0;
      pulse(1'b0);
      while (valid_n !== 1'b1 && cyc < 7000) @(posedge i_clk);
      first = data_n;
      repeat (6) @(posedge i_clk);
      chk(data_n, first);
      chk(valid_n, 1'b1);
      ready <= 1'b1;
      wait_done();
      chk(qn.size(), 2);
      chk(qn[0], {code_tab[1][1], sdi_val[3:2]});
      chk(qn[1], {code_tab[1][3], sdi_val[7:6]});
      $display("test stall done");
   endtask : t_stall

   // Configuration copies follow the inputs while idle.
   task automatic t_config();
      chan_en <= 4'b0111;
      gain <= 8'b11_10_01_00;
      bipolar <= 4'b0101;
      repeat (3) @(posedge i_clk);
      chk(o_en, 4'b0111);
      chk(o_gain, 8'b11_10_01_00);
      chk(o_bip, 4'b0101);
      $display("test config done");
   endtask : t_config

   // A scan interval shorter than one scan loses ticks and raises the sticky overrun flag.
   task automatic t_overrun();
      qn.delete();
      scan_mode <= 1'b1;
      interval <= 24'h00_0010;
      count <= 24'h00_0002;
      trig <= 1'b1;
      pulse(1'b1);
      repeat (4) @(posedge i_clk);
      chk(acq_active, 1'b1);
      wait_done();
      chk(overrun, 1'b1);
      chk(qn.size(), 6);
      chk(acq_active, 1'b0);
      trig <= 1'b0;
      scan_mode <= 1'b0;
      $display("test overrun done");
   endtask : t_overrun

   // Armed scan: nothing before the trigger, then two timed scans.
   task automatic t_scan();
      int s0;
      qn.delete();
      scan_mode <= 1'b1;
      interval <= 24'h00_012C;
      count <= 24'h00_0002;
      s0 = nstrobe;
      pulse(1'b1);
      repeat (40) @(posedge i_clk);
      chk(nstrobe, s0);
      trig <= 1'b1;
      wait_done();
      chk(nstrobe, s0 + 2);
      chk(qn.size(), 6);
      chk(overrun, 1'b0);
      trig <= 1'b0;
      scan_mode <= 1'b0;
      $display("test scan done");
   endtask : t_scan

   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test

   // Offset binary converter codes and the two's complement each must become.
   // The narrow variant sees only the low 14 bits of the wide straight binary codes.
   initial begin
      raw_tab[0] = '{16'h3FFF, 16'h2000, 16'h1FFF, 16'h0000};
      code_tab[0] = '{14'h1FFF, 14'h0000, 14'h3FFF, 14'h2000};
      raw_tab[1] = '{16'hFFFF, 16'h8001, 16'h8000, 16'h7FFF};
      code_tab[1] = '{14'h1FFF, 14'h2001, 14'h2000, 14'h1FFF};
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      chan_en <= 4'hF;
      bipolar <= 4'hF;
      repeat (2) @(posedge i_clk);
      t_codes();
      t_stall();
      t_config();
      t_overrun();
      t_scan();
      finish_test();
   end
endmodule : tb
`default_nettype wire
